//--- hdl/tmr8_cfg.svh
// Constants for the 8-bit timer with one compare unit
`ifndef TMR8_CFG_SVH
`define TMR8_CFG_SVH
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_MAX_PREV 8'hfe
`define TMR8_RST_CNT 8'h00
`define TMR8_RST_CMP 8'h00
`define TMR8_CS_STOP 3'h0
`define TMR8_CS_EXT_FALL 3'h6
`define TMR8_CS_EXT_RISE 3'h7
`define TMR8_COM_NONE 2'h0
`define TMR8_COM_TOGGLE 2'h1
`define TMR8_COM_CLEAR 2'h2
`define TMR8_COM_SET 2'h3
`endif

//--- hdl/tmr8_pkg.sv
// Types for the 8-bit timer with one compare unit
package tmr8_pkg;
   // Waveform modes
   typedef enum logic [1:0] {
      TMR8_WGM_NORMAL = 2'h0,
      TMR8_WGM_PHASE = 2'h1,
      TMR8_WGM_CTC = 2'h2,
      TMR8_WGM_FAST = 2'h3
   } tmr8_wgm_t;

   // Counter direction state, one-hot
   typedef enum logic [1:0] {
      TMR8_DIR_UP = 2'h1,
      TMR8_DIR_DOWN = 2'h2
   } tmr8_dir_t;

   // Control bits travelling together
   typedef struct packed {
      logic [2:0] clock_select_field;
      tmr8_wgm_t waveform_mode_field;
      logic [1:0] compare_output_action;
   } tmr8_ctrl_t;

   // Interrupt flag and mask bits
   typedef struct packed {
      logic compare_match_flag;
      logic overflow_flag;
   } tmr8_irq_t;
endpackage

//--- hdl/tmr8_timer.sv
// 8-bit timer/counter with one double-buffered compare unit
`timescale 1ns/1ps
`include "tmr8_cfg.svh"
//
// Functional notes
// - Counter and compare value are 8-bit registers, readable and writable.
// - Tick comes from prescaled clock or external pin, with selectable edge.
// - Clock select zero gives no tick; counter stays stopped.
// - Counter may be read and written at any time.
// - Counter write beats a coincident count or clear.
// - Each tick clears, increments or decrements per waveform mode.
// - Bottom is 0x00, maximum is 0xFF.
// - Top is 0xFF or the compare value, by mode.
// - Equality sets the compare match flag at the following tick.
// - Compare request needs flag, compare enable and global enable.
// - Compare match flag clears when its interrupt is serviced.
// - Writing one to the flag bit clears it.
// - Requests show in the flag register and are masked individually.
// - Overflow flag sets at a mode-defined point and can interrupt.
// - PWM modes write compare into a buffer; others write it directly.
// - Buffered compare value loads only at top or bottom.
// - Force strobe updates output like a match in non-PWM modes only.
// - Counter write blocks compare match for the next tick, even stopped.
// - Compare output state survives waveform mode changes.
// - Output action bits take effect immediately, unbuffered.
// - Mode 0 counts up, wraps, sets overflow when counter becomes zero.
// - Mode 2 clears counter on compare match; compare is top.
// - Mode 3 is single slope to maximum; overflow at maximum.
// - Reset clears the internal compare output register.

module tmr8_timer (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire tmr8_pkg::tmr8_ctrl_t i_ctrl,
   input wire logic i_prescale_tick,
   input wire logic i_external_count_pin,
   input wire logic i_cnt_wr,
   input wire logic [7:0] i_cnt_wdata,
   input wire logic i_cmp_wr,
   input wire logic [7:0] i_cmp_wdata,
   input wire logic i_force_compare_strobe,
   input wire tmr8_pkg::tmr8_irq_t i_flag_clr,
   input wire tmr8_pkg::tmr8_irq_t i_irq_mask,
   input wire logic i_global_irq_en,
   input wire tmr8_pkg::tmr8_irq_t i_irq_ack,
   output logic [7:0] o_count_value,
   output logic [7:0] o_compare_value,
   output tmr8_pkg::tmr8_irq_t o_irq_flags,
   output tmr8_pkg::tmr8_irq_t o_irq_req,
   output logic o_compare_output,
   output logic o_pin_override
);

   // ****************************************************
   // Tick generation
   // ****************************************************
   logic ext_meta_ff;
   logic ext_sync_ff;
   logic ext_prev_ff;
   logic timer_tick;
   logic ext_rise;
   logic ext_fall;

   // External pin is asynchronous; two flops before any edge logic
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_meta_ff <= 1'b0;
         ext_sync_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
      end else begin
         ext_meta_ff <= i_external_count_pin;
         ext_sync_ff <= ext_meta_ff;
         ext_prev_ff <= ext_sync_ff;
      end
   end

   assign ext_rise = ext_sync_ff & ~ext_prev_ff;
   assign ext_fall = ~ext_sync_ff & ext_prev_ff;

   // Source and edge choice; prescaler taps live outside this block
   always_comb begin
      case (i_ctrl.clock_select_field)
         `TMR8_CS_STOP: timer_tick = 1'b0;
         `TMR8_CS_EXT_FALL: timer_tick = ext_fall;
         `TMR8_CS_EXT_RISE: timer_tick = ext_rise;
         default: timer_tick = i_prescale_tick;
      endcase
   end

   // ****************************************************
   // Counter unit
   // ****************************************************
   logic [7:0] cnt_ff;
   logic [7:0] ocr_ff;
   logic [7:0] ocr_buf_ff;
   tmr8_pkg::tmr8_dir_t dir_ff;
   logic block_ff;
   logic is_pwm;
   logic at_bottom;
   logic at_max;
   logic match;
   logic [7:0] top_val;

   // PWM modes use buffering and forbid forcing
   function automatic logic pwm_mode(input tmr8_pkg::tmr8_wgm_t m);
      pwm_mode = (m == tmr8_pkg::TMR8_WGM_PHASE) || (m == tmr8_pkg::TMR8_WGM_FAST);
   endfunction

   assign is_pwm = pwm_mode(i_ctrl.waveform_mode_field);
   assign at_bottom = (cnt_ff == `TMR8_BOTTOM);
   assign at_max = (cnt_ff == `TMR8_MAX);
   assign top_val = (i_ctrl.waveform_mode_field == tmr8_pkg::TMR8_WGM_CTC) ?
                    ocr_ff : `TMR8_MAX;
   assign match = (cnt_ff == ocr_ff);

   // Counter: a processor write always wins over the tick
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= `TMR8_RST_CNT;
      end else if (i_cnt_wr) begin
         cnt_ff <= i_cnt_wdata;
      end else if (timer_tick) begin
         case (i_ctrl.waveform_mode_field)
            tmr8_pkg::TMR8_WGM_CTC: begin
               cnt_ff <= (cnt_ff == top_val) ? `TMR8_BOTTOM : cnt_ff + 8'h01;
            end
            tmr8_pkg::TMR8_WGM_PHASE: begin
               if (dir_ff == tmr8_pkg::TMR8_DIR_UP && !at_max) begin
                  cnt_ff <= cnt_ff + 8'h01;
               end else if (dir_ff == tmr8_pkg::TMR8_DIR_UP) begin
                  cnt_ff <= cnt_ff - 8'h01;
               end else if (!at_bottom) begin
                  cnt_ff <= cnt_ff - 8'h01;
               end else begin
                  cnt_ff <= cnt_ff + 8'h01;
               end
            end
            default: cnt_ff <= cnt_ff + 8'h01; // wraps at max
         endcase
      end
   end

   // Direction for dual slope: turn at max and bottom
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dir_ff <= tmr8_pkg::TMR8_DIR_UP;
      end else if (i_ctrl.waveform_mode_field != tmr8_pkg::TMR8_WGM_PHASE) begin
         dir_ff <= tmr8_pkg::TMR8_DIR_UP;
      end else if (timer_tick && !i_cnt_wr) begin
         case (dir_ff)
            tmr8_pkg::TMR8_DIR_UP: if (at_max) dir_ff <= tmr8_pkg::TMR8_DIR_DOWN;
            tmr8_pkg::TMR8_DIR_DOWN: if (at_bottom) dir_ff <= tmr8_pkg::TMR8_DIR_UP;
            default: dir_ff <= tmr8_pkg::TMR8_DIR_UP;
         endcase
      end
   end

   // ****************************************************
   // Compare register and buffer
   // ****************************************************
   // Buffer captures writes in every mode
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ocr_buf_ff <= `TMR8_RST_CMP;
      end else if (i_cmp_wr) begin
         ocr_buf_ff <= i_cmp_wdata;
      end
   end

   // Active compare: direct in non-PWM, reload at top/bottom in PWM
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ocr_ff <= `TMR8_RST_CMP;
      end else if (!is_pwm) begin
         if (i_cmp_wr) begin
            ocr_ff <= i_cmp_wdata;
         end
      end else if (timer_tick && (at_max || at_bottom)) begin
         ocr_ff <= ocr_buf_ff;
      end
   end

   // Readback shows the buffer in PWM modes, the active value otherwise
   assign o_compare_value = is_pwm ? ocr_buf_ff : ocr_ff;
   assign o_count_value = cnt_ff;

   // Block lasts until the next tick, so it holds while the timer is stopped
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         block_ff <= 1'b0;
      end else if (i_cnt_wr) begin
         block_ff <= 1'b1;
      end else if (timer_tick) begin
         block_ff <= 1'b0;
      end
   end

   logic match_evt;
   assign match_evt = timer_tick && match && !block_ff && !i_cnt_wr;

   // ****************************************************
   // Flags and requests
   // ****************************************************
   logic ovf_evt;
   tmr8_pkg::tmr8_irq_t flags_ff;

   // Overflow point per mode
   always_comb begin
      case (i_ctrl.waveform_mode_field)
         tmr8_pkg::TMR8_WGM_NORMAL: ovf_evt = timer_tick && at_max; // zero next
         tmr8_pkg::TMR8_WGM_CTC: ovf_evt = timer_tick && at_max && !match;
         tmr8_pkg::TMR8_WGM_FAST: ovf_evt = timer_tick && (cnt_ff == `TMR8_MAX_PREV);
         default: ovf_evt = timer_tick && at_bottom
                            && (dir_ff == tmr8_pkg::TMR8_DIR_DOWN);
      endcase
      // The write wins over the count, so that tick raises no overflow
      if (i_cnt_wr) begin
         ovf_evt = 1'b0;
      end
   end

   // Set wins over a same-cycle clear or acknowledge
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_ff <= '0;
      end else begin
         if (match_evt) begin
            flags_ff.compare_match_flag <= 1'b1;
         end else if (i_flag_clr.compare_match_flag || i_irq_ack.compare_match_flag) begin
            flags_ff.compare_match_flag <= 1'b0;
         end
         if (ovf_evt) begin
            flags_ff.overflow_flag <= 1'b1;
         end else if (i_flag_clr.overflow_flag || i_irq_ack.overflow_flag) begin
            flags_ff.overflow_flag <= 1'b0;
         end
      end
   end

   assign o_irq_flags = flags_ff;
   assign o_irq_req = (flags_ff & i_irq_mask) & {2{i_global_irq_en}};

   // ****************************************************
   // Compare output unit
   // ****************************************************
   logic oc_ff;
   logic force_evt;
   assign force_evt = i_force_compare_strobe && !is_pwm;

   // Action bits act immediately; mode switches leave oc_ff as it is
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oc_ff <= 1'b0;
      end else if (!is_pwm) begin
         if (match_evt || force_evt) begin
            case (i_ctrl.compare_output_action)
               `TMR8_COM_TOGGLE: oc_ff <= ~oc_ff;
               `TMR8_COM_CLEAR: oc_ff <= 1'b0;
               `TMR8_COM_SET: oc_ff <= 1'b1;
               default: oc_ff <= oc_ff;
            endcase
         end
      end else if (i_ctrl.compare_output_action[1]) begin
         // PWM: action bit 0 selects inverting output
         if (match_evt) begin
            // Dual slope: a match on the way down undoes the one on the way up
            oc_ff <= i_ctrl.compare_output_action[0]
                     ^ (dir_ff == tmr8_pkg::TMR8_DIR_DOWN);
         end else if (timer_tick && i_ctrl.waveform_mode_field == tmr8_pkg::TMR8_WGM_FAST
                      && at_max) begin
            oc_ff <= ~i_ctrl.compare_output_action[0];
         end
      end
   end

   assign o_compare_output = oc_ff;
   assign o_pin_override = (i_ctrl.compare_output_action != `TMR8_COM_NONE);

   // ****************************************************
   // Checks
   // ****************************************************
   AST_STOPPED_HOLDS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ctrl.clock_select_field == `TMR8_CS_STOP && !i_cnt_wr) |=> $stable(cnt_ff))
      else $error("Counter moved while stopped");
   AST_WRITE_WINS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_cnt_wr |=> (cnt_ff == $past(i_cnt_wdata)))
      else $error("Counter write lost");
   AST_MATCH_FLAG: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      match_evt |=> flags_ff.compare_match_flag)
      else $error("Match did not set flag");
   AST_IRQ_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_irq_req.compare_match_flag == (flags_ff.compare_match_flag
         && i_irq_mask.compare_match_flag && i_global_irq_en))
      else $error("Compare request gating wrong");
   AST_SW_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_flag_clr.compare_match_flag && !match_evt) |=> !flags_ff.compare_match_flag)
      else $error("Flag clear ignored");
   AST_DIRECT_CMP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_cmp_wr && !is_pwm) |=> (ocr_ff == $past(i_cmp_wdata)))
      else $error("Direct compare write lost");
   sequence cnt_write_then_tick;
      i_cnt_wr ##1 (!i_cnt_wr && timer_tick);
   endsequence
   AST_BLOCK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      cnt_write_then_tick |-> !match_evt)
      else $error("Match not blocked after counter write");
   AST_FORCE_NO_FLAG: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (force_evt && !match_evt && !flags_ff.compare_match_flag) |=>
         !flags_ff.compare_match_flag)
      else $error("Force set the flag");
   AST_NORMAL_WRAP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (timer_tick && !i_cnt_wr && at_max
         && i_ctrl.waveform_mode_field == tmr8_pkg::TMR8_WGM_NORMAL)
      |=> (cnt_ff == `TMR8_BOTTOM && flags_ff.overflow_flag))
      else $error("Normal wrap wrong");
   AST_PIN_OVR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_pin_override == (i_ctrl.compare_output_action != `TMR8_COM_NONE))
      else $error("Override wrong");

endmodule

//--- verification/tmr8_cpu_model.sv
// Processor core model that services the timer interrupt requests
`timescale 1ns/1ps
module tmr8_cpu_model (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire tmr8_pkg::tmr8_irq_t i_irq_req,
   input wire logic [3:0] i_ack_delay,
   output tmr8_pkg::tmr8_irq_t o_irq_ack
);
   // ****************************************
   // Interrupt service
   // ****************************************
   logic [3:0] wait_cnt;
   // Acts on the falling edge like all stimulus; one request at a time,
   // compare before overflow, after a latency the bench can stretch
   always @(negedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq_ack <= '0;
         wait_cnt <= 4'h0;
      end else begin
         o_irq_ack <= '0;
         wait_cnt <= 4'h0;
         if (o_irq_ack == '0 && i_irq_req != '0) begin
            if (wait_cnt < i_ack_delay) begin
               wait_cnt <= wait_cnt + 4'h1;
            end else if (i_irq_req.compare_match_flag) begin
               o_irq_ack.compare_match_flag <= 1'b1;
            end else begin
               o_irq_ack.overflow_flag <= 1'b1;
            end
         end
      end
   end
endmodule

//--- verification/timer8_single_compare_bench.sv
// Self-checking bench for the 8-bit timer with one compare unit
`timescale 1ns/1ps
module timer8_single_compare_bench;
   localparam tmr8_pkg::tmr8_wgm_t NRM = tmr8_pkg::TMR8_WGM_NORMAL;
   localparam tmr8_pkg::tmr8_wgm_t PHS = tmr8_pkg::TMR8_WGM_PHASE;
   localparam tmr8_pkg::tmr8_wgm_t CLEAR_ON_MATCH_MODE = tmr8_pkg::TMR8_WGM_CTC;
   localparam tmr8_pkg::tmr8_wgm_t FST = tmr8_pkg::TMR8_WGM_FAST;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   tmr8_pkg::tmr8_ctrl_t ctrl = '0;
   logic pre = 1'b0;
   logic ext = 1'b0;
   logic cnt_wr = 1'b0;
   logic [7:0] cnt_wd = 8'h00;
   logic cmp_wr = 1'b0;
   logic [7:0] cmp_wd = 8'h00;
   logic frc = 1'b0;
   tmr8_pkg::tmr8_irq_t clr_s = '0;
   tmr8_pkg::tmr8_irq_t mask = '0;
   logic gie = 1'b0;
   logic [3:0] ack_delay = 4'h0;
   tmr8_pkg::tmr8_irq_t ack;
   tmr8_pkg::tmr8_irq_t flags;
   tmr8_pkg::tmr8_irq_t req;
   logic [7:0] cnt;
   logic [7:0] cmp;
   logic oc;
   logic ovr;
   int error_cnt = 0;
   int comparisons = 0;
   integer seed = 32'hba00;
   logic [7:0] v;
   int i;

   tmr8_timer i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ctrl(ctrl), .i_prescale_tick(pre),
      .i_external_count_pin(ext), .i_cnt_wr(cnt_wr), .i_cnt_wdata(cnt_wd), .i_cmp_wr(cmp_wr),
      .i_cmp_wdata(cmp_wd), .i_force_compare_strobe(frc), .i_flag_clr(clr_s),
      .i_irq_mask(mask), .i_global_irq_en(gie), .i_irq_ack(ack), .o_count_value(cnt),
      .o_compare_value(cmp), .o_irq_flags(flags), .o_irq_req(req), .o_compare_output(oc),
      .o_pin_override(ovr));
   tmr8_cpu_model i_cpu (.i_sys_clk(clk), .i_rst_n(rst_n), .i_irq_req(req),
      .i_ack_delay(ack_delay), .o_irq_ack(ack));

   // ****************************************
   // Drivers and checks
   // ****************************************
   // 100 ns period
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic results();
      $display("Mismatches %0d in %0d comparisons", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Strobes are raised on a falling edge and dropped on the next one
   task automatic tick(input int n);
      repeat (n) begin
         @(negedge clk) pre = 1'b1;
         @(negedge clk) pre = 1'b0;
      end
   endtask
   task automatic wr_cnt(input logic [7:0] d, input logic t);
      @(negedge clk);
      {cnt_wr, cnt_wd, pre} = {1'b1, d, t};
      @(negedge clk);
      {cnt_wr, pre} = 2'h0;
   endtask
   task automatic wr_cmp(input logic [7:0] d);
      @(negedge clk);
      {cmp_wr, cmp_wd} = {1'b1, d};
      @(negedge clk) cmp_wr = 1'b0;
   endtask
   task automatic force_oc();
      @(negedge clk) frc = 1'b1;
      @(negedge clk) frc = 1'b0;
   endtask
   task automatic clr_flags();
      @(negedge clk) clr_s = 2'h3;
      @(negedge clk) clr_s = 2'h0;
   endtask
   task automatic set_ctrl(input logic [2:0] cs, input tmr8_pkg::tmr8_wgm_t m,
                           input logic [1:0] a);
      @(negedge clk) ctrl = '{cs, m, a};
      #1;
   endtask
   // The pin passes a synchroniser, so the count may lag by a few cycles
   task automatic ext_edge(input logic lvl, input logic [7:0] exp);
      int k;
      @(negedge clk) ext = lvl;
      for (k = 0; k < 10 && cnt !== exp; k++) begin
         @(negedge clk);
      end
      if (k == 10) begin
         error_cnt++;
         $display("FAIL %0t: pin edge not counted", $time);
         results();
      end
      repeat (4) @(negedge clk);
      chk8(cnt, exp);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      chk8(cnt, 8'h00);
      chk8(cmp, 8'h00);
      chk1(oc, 1'b0);
      // Stopped timer: random writes read back and ticks are ignored
      repeat (8) begin
         v = 8'($random(seed));
         wr_cnt(v, 1'b0);
         chk8(cnt, v);
         tick(2);
         chk8(cnt, v);
      end
      set_ctrl(3'h1, NRM, 2'h0);
      wr_cnt(8'h5a, 1'b1);
      chk8(cnt, 8'h5a);
      wr_cnt(8'hff, 1'b0);
      tick(1);
      chk8(cnt, 8'h00);
      chk1(flags.overflow_flag, 1'b1);
      gie = 1'b1;
      #1 chk1(req.overflow_flag, 1'b0);
      mask.overflow_flag = 1'b1;
      #1 chk1(req.overflow_flag, 1'b1);
      repeat (3) @(negedge clk);
      chk1(flags.overflow_flag, 1'b0);
      // Normal-mode match toggles the output; request serviced slowly
      v = 8'h10 + {1'b0, 7'($random(seed))};
      wr_cmp(v);
      chk8(cmp, v);
      set_ctrl(3'h1, NRM, 2'h1);
      wr_cnt(v - 8'h02, 1'b0);
      tick(2);
      chk1(flags.compare_match_flag, 1'b0);
      tick(1);
      chk1(flags.compare_match_flag, 1'b1);
      chk1(oc, 1'b1);
      {mask, gie, ack_delay} = {2'h2, 1'b0, 4'h3};
      #1 chk1(req.compare_match_flag, 1'b0);
      gie = 1'b1;
      #1 chk1(req.compare_match_flag, 1'b1);
      for (i = 0; i < 10 && flags.compare_match_flag !== 1'b0; i++) @(negedge clk);
      chk1(flags.compare_match_flag, 1'b0);
      mask = 2'h0;
      // A write equal to the compare value must hide the next match
      set_ctrl(3'h0, NRM, 2'h0);
      wr_cnt(v, 1'b0);
      set_ctrl(3'h1, NRM, 2'h0);
      tick(1);
      chk8(cnt, v + 8'h01);
      chk1(flags.compare_match_flag, 1'b0);
      // Forced compare, mode change and pin override
      set_ctrl(3'h0, NRM, 2'h2);
      force_oc();
      chk1(oc, 1'b0);
      set_ctrl(3'h0, NRM, 2'h3);
      force_oc();
      chk1(oc, 1'b1);
      chk1(flags.compare_match_flag, 1'b0);
      chk8(cnt, v + 8'h01);
      set_ctrl(3'h0, FST, 2'h2);
      force_oc();
      chk1(oc, 1'b1);
      set_ctrl(3'h0, PHS, 2'h0);
      @(negedge clk);
      chk1(oc, 1'b1);
      for (i = 0; i < 4; i++) begin
         set_ctrl(3'h0, NRM, i[1:0]);
         chk1(ovr, i != 0);
      end
      // Clear on match with a top of 3
      wr_cmp(8'h03);
      wr_cnt(8'h00, 1'b0);
      set_ctrl(3'h1, CLEAR_ON_MATCH_MODE, 2'h0);
      for (i = 1; i < 5; i++) begin
         tick(1);
         chk8(cnt, 8'(i % 4));
      end
      chk1(flags.compare_match_flag, 1'b1);
      clr_flags();
      chk8({6'h00, flags}, 8'h00);
      // Fast mode: compare write is buffered until the top
      set_ctrl(3'h1, FST, 2'h2);
      wr_cmp(8'h80);
      chk8(cmp, 8'h80);
      wr_cnt(8'h01, 1'b0);
      tick(3);
      chk1(flags.compare_match_flag, 1'b1);
      chk1(oc, 1'b0);
      clr_flags();
      wr_cnt(8'hfe, 1'b0);
      tick(1);
      chk8(cnt, 8'hff);
      chk1(flags.overflow_flag, 1'b1);
      tick(1);
      chk8(cnt, 8'h00);
      chk1(oc, 1'b1);
      clr_flags();
      wr_cnt(8'h7e, 1'b0);
      tick(3);
      chk1(flags.compare_match_flag, 1'b1);
      chk1(oc, 1'b0);
      // Dual slope turns round at maximum
      set_ctrl(3'h1, PHS, 2'h0);
      wr_cnt(8'hfe, 1'b0);
      tick(3);
      chk8(cnt, 8'hfd);
      // Counting down: overflow comes when the slope turns at bottom
      wr_cnt(8'h01, 1'b0);
      tick(1);
      chk8(cnt, 8'h00);
      chk1(flags.overflow_flag, 1'b0);
      tick(1);
      chk8(cnt, 8'h01);
      chk1(flags.overflow_flag, 1'b1);
      // External pin, rising then falling edge
      set_ctrl(3'h0, NRM, 2'h0);
      wr_cnt(8'h10, 1'b0);
      set_ctrl(3'h7, NRM, 2'h0);
      ext_edge(1'b1, 8'h11);
      set_ctrl(3'h6, NRM, 2'h0);
      ext_edge(1'b0, 8'h12);
      results();
   end
endmodule
